/* rtl/fat_pkg.sv */
// Purpose: Shared constants for the fetch address trap block
// Assumes: 100 MHz system clock, high-frequency clock equal to it
// Notes:   Address windows are plain defaults, adjust per memory map
package fat_pkg;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL_ONE   = 8'h00;
    localparam logic [7:0]  OFS_CODE       = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;
    localparam logic [7:0]  OFS_MASK       = 8'h0c;
    localparam logic [7:0]  OFS_STATE      = 8'h10;
    // Field positions in watchdog_control_one
    localparam int          BIT_RAM_SEL    = 5;
    localparam int          BIT_ACTION     = 4;
    // Reset values
    localparam logic        RST_RAM_SEL    = 1'b1;
    localparam logic        RST_ACTION     = 1'b1;
    localparam logic [1:0]  RST_MASK       = 2'h0;
    // Codes written to watchdog_code_register
    localparam logic [7:0]  CODE_TRAP_AREA = 8'hd2;
    localparam logic [7:0]  CODE_WDT_CLEAR = 8'h4e;
    localparam logic [7:0]  CODE_WDT_OFF   = 8'hb1;
    // Status bits
    localparam int          EVT_NMI        = 0;
    localparam int          EVT_RESET      = 1;
    localparam int          EVT_W          = 2;
    // Fetch address windows
    localparam logic [15:0] SFR_LO         = 16'h0000;
    localparam logic [15:0] SFR_HI         = 16'h003f;
    localparam logic [15:0] RAM_LO         = 16'h0040;
    localparam logic [15:0] RAM_HI         = 16'h023f;
    // Trap reset length: at most 24 periods of the high-frequency clock
    localparam longint      CLK_HZ         = 64'd100_000_000;
    localparam longint      FC_HZ          = 64'd100_000_000;
    localparam longint      RST_FC_PERIODS = 64'd24;
    localparam int          RST_CYC        = int'((RST_FC_PERIODS * CLK_HZ) / FC_HZ);
    localparam logic [4:0]  RST_CYC_W      = 5'(RST_CYC);
    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    typedef enum logic [0:0] {
        FAT_RG_IDLE = 1'b0,
        FAT_RG_HOLD = 1'b1
    } fat_rg_state_t;
endpackage : fat_pkg

/* rtl/fat_reg_if.sv */
// Purpose: Register access carrier between bus slave and trap core
// Assumes: Single clock, one access of each kind per cycle
// Notes:   Read data is combinational from the core
`timescale 1ns/1ps
interface fat_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;
    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  input wr_err, rd_data, rd_err);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface : fat_reg_if

/* rtl/fat_axil.sv */
// Purpose: AXI4-Lite slave front end for the trap registers
// Assumes: Master keeps valid and payload stable until taken
// Notes:   Write answers one cycle after both halves are held
`timescale 1ns/1ps
module fat_axil (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output      logic        wready,
    output      logic [1:0]  bresp,
    output      logic        bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output      logic        arready,
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    output      logic        rvalid,
    input  wire logic        rready,
    fat_reg_if.bus           rb
);
    import fat_pkg::*;
    logic        aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
    logic [7:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [3:0]  ws_r, ws_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
    logic        do_wr;

    // Either half may arrive first; each is held until the pair completes
    assign awready = !aw_r && !bv_r;
    assign wready  = !w_r && !bv_r;
    assign arready = !rv_r;
    assign do_wr   = aw_r && w_r;
    assign rb.wr_en   = do_wr;
    assign rb.wr_addr = awa_r;
    assign rb.wr_data = wd_r;
    assign rb.wr_strb = ws_r;
    assign rb.rd_en   = arvalid && arready;
    assign rb.rd_addr = araddr;

    always_comb
    begin
        aw_nxt  = aw_r;
        w_nxt   = w_r;
        awa_nxt = awa_r;
        wd_nxt  = wd_r;
        ws_nxt  = ws_r;
        bv_nxt  = bv_r;
        br_nxt  = br_r;
        rv_nxt  = rv_r;
        rd_nxt  = rd_r;
        rr_nxt  = rr_r;
        if (awvalid && awready)
        begin
            aw_nxt  = 1'b1;
            awa_nxt = awaddr;
        end
        if (wvalid && wready)
        begin
            w_nxt  = 1'b1;
            wd_nxt = wdata;
            ws_nxt = wstrb;
        end
        if (do_wr)
        begin
            aw_nxt = 1'b0;
            w_nxt  = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = rb.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (bv_r && bready)
            bv_nxt = 1'b0;
        if (rb.rd_en)
        begin
            rv_nxt = 1'b1;
            rd_nxt = rb.rd_data;
            rr_nxt = rb.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (rv_r && rready)
            rv_nxt = 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            aw_r  <= 1'b0;
            w_r   <= 1'b0;
            awa_r <= 8'h00;
            wd_r  <= 32'h0000_0000;
            ws_r  <= 4'h0;
            bv_r  <= 1'b0;
            br_r  <= 2'h0;
            rv_r  <= 1'b0;
            rd_r  <= 32'h0000_0000;
            rr_r  <= 2'h0;
        end
        else
        begin
            aw_r  <= aw_nxt;
            w_r   <= w_nxt;
            awa_r <= awa_nxt;
            wd_r  <= wd_nxt;
            ws_r  <= ws_nxt;
            bv_r  <= bv_nxt;
            br_r  <= br_nxt;
            rv_r  <= rv_nxt;
            rd_r  <= rd_nxt;
            rr_r  <= rr_nxt;
        end
    end

    assign bvalid = bv_r;
    assign bresp  = br_r;
    assign rvalid = rv_r;
    assign rdata  = rd_r;
    assign rresp  = rr_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped before taken");
    rd_turn_a: assert property (arvalid && arready |=> rvalid)
        else $error("Read answer not one cycle after address");
endmodule : fat_axil

/* rtl/fat_rstgen.sv */
// Purpose: Stretches a trap reset request into a bounded reset pulse
// Assumes: Start is a one-cycle pulse on the system clock
// Notes:   Requests during a running pulse are absorbed
`timescale 1ns/1ps
module fat_rstgen (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output      logic busy
);
    import fat_pkg::*;
    fat_rg_state_t st_r, st_nxt;
    logic [4:0]    cnt_r, cnt_nxt;

    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            FAT_RG_IDLE:
                if (start)
                begin
                    st_nxt  = FAT_RG_HOLD;
                    cnt_nxt = RST_CYC_W - 5'd1;
                end
            FAT_RG_HOLD:
                if (cnt_r == 5'd0)
                    st_nxt = FAT_RG_IDLE;
                else
                    cnt_nxt = cnt_r - 5'd1;
            default:
                st_nxt = FAT_RG_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r  <= FAT_RG_IDLE;
            cnt_r <= 5'd0;
        end
        else
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Held exactly the full bound; shorter would risk an incomplete reset
    assign busy = (st_r == FAT_RG_HOLD);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rst_len_a: assert property (start && !busy |=> busy [*8] ##16 busy ##1 !busy)
        else $error("Trap reset length not 24 cycles");
endmodule : fat_rstgen

/* rtl/fat_trap.sv */
// Purpose: Fetch address trap unit with AXI4-Lite register access
// Assumes: Fetch and CPU handshake inputs come from the system clock
// Notes:   Watchdog counter itself lives outside; only its codes go out
//
// Overview of operation
// - RAM fetches trap only while selected
// - RAM select applies on trap area code
// - Special area fetches always trap; here none trap while the trap reset is held
// - Action bit picks interrupt or reset
// - Trap interrupt ignores master flag
// - Trap preempts interrupt already in service
// - Trap reset held at most 24 periods
// - Slow mode trap reset restarts oscillator
// - Code register decodes three codes only
// - Trap bits share watchdog control addresses
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module fat_trap (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic [7:0]   S_AXI_AWADDR,
    input  wire logic         S_AXI_AWVALID,
    output      logic         S_AXI_AWREADY,
    input  wire logic [31:0]  S_AXI_WDATA,
    input  wire logic [3:0]   S_AXI_WSTRB,
    input  wire logic         S_AXI_WVALID,
    output      logic         S_AXI_WREADY,
    output      logic [1:0]   S_AXI_BRESP,
    output      logic         S_AXI_BVALID,
    input  wire logic         S_AXI_BREADY,
    input  wire logic [7:0]   S_AXI_ARADDR,
    input  wire logic         S_AXI_ARVALID,
    output      logic         S_AXI_ARREADY,
    output      logic [31:0]  S_AXI_RDATA,
    output      logic [1:0]   S_AXI_RRESP,
    output      logic         S_AXI_RVALID,
    input  wire logic         S_AXI_RREADY,
    input  wire logic         FETCH_VALID,
    input  wire logic [15:0]  FETCH_ADDR,
    input  wire logic         SLOW_MODE,
    input  wire logic         TRAP_ACK,
    output      logic         TRAP_NMI,
    output      logic         TRAP_RESET,
    output      logic         HFOSC_RESTART,
    output      logic         WDT_CLEAR,
    output      logic         WDT_DISABLE,
    output      logic         IRQ
);
    import fat_pkg::*;

    fat_reg_if rb ();

    logic               ram_sel_r, ram_sel_nxt;
    logic               ram_live_r, ram_live_nxt;
    logic               action_r, action_nxt;
    logic               nmi_r, nmi_nxt;
    logic               osc_r, osc_nxt;
    logic               clr_r, clr_nxt;
    logic               off_r, off_nxt;
    logic [EVT_W-1:0]   stat_r, stat_nxt;
    logic [EVT_W-1:0]   mask_r, mask_nxt;
    logic [EVT_W-1:0]   evt;
    logic               in_sfr, in_ram, trap_hit, trap_nmi, trap_rst;
    logic               rst_busy, wr_lane0;
    logic [7:0]         wbyte;

    fat_axil u_bus (
        .clk     (CLK),
        .rst     (RST),
        .awaddr  (S_AXI_AWADDR),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .bresp   (S_AXI_BRESP),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .araddr  (S_AXI_ARADDR),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .rb      (rb.bus)
    );

    fat_rstgen u_rst (
        .clk   (CLK),
        .rst   (RST),
        .start (trap_rst),
        .busy  (rst_busy)
    );

    // Address windows of the fetch
    assign in_sfr   = (FETCH_ADDR >= SFR_LO) && (FETCH_ADDR <= SFR_HI);
    assign in_ram   = (FETCH_ADDR >= RAM_LO) && (FETCH_ADDR <= RAM_HI);
    // Outside a held trap reset the special area always traps, RAM only with the applied select
    assign trap_hit = FETCH_VALID && !rst_busy
                      && (in_sfr || (in_ram && ram_live_r));
    assign trap_nmi = trap_hit && !action_r;
    assign trap_rst = trap_hit && action_r;

    assign wr_lane0 = rb.wr_en && rb.wr_strb[0];
    assign wbyte    = rb.wr_data[7:0];
    assign evt      = {trap_rst, trap_nmi};

    // Register writes, code decode and trap state
    always_comb
    begin
        ram_sel_nxt  = ram_sel_r;
        ram_live_nxt = ram_live_r;
        action_nxt   = action_r;
        nmi_nxt      = nmi_r;
        mask_nxt     = mask_r;
        stat_nxt     = stat_r;
        clr_nxt      = 1'b0;
        off_nxt      = 1'b0;
        osc_nxt      = trap_rst && SLOW_MODE;
        // Trap bits sit beside the watchdog fields in the same register
        if (wr_lane0 && rb.wr_addr == OFS_CTRL_ONE)
        begin
            ram_sel_nxt = wbyte[BIT_RAM_SEL];
            action_nxt  = wbyte[BIT_ACTION];
        end
        if (wr_lane0 && rb.wr_addr == OFS_CODE)
        begin
            case (wbyte)
                CODE_TRAP_AREA: ram_live_nxt = ram_sel_r;
                CODE_WDT_CLEAR: clr_nxt = 1'b1;
                CODE_WDT_OFF:   off_nxt = 1'b1;
                default:        ram_live_nxt = ram_live_r;
            endcase
        end
        if (wr_lane0 && rb.wr_addr == OFS_MASK)
            mask_nxt = wbyte[EVT_W-1:0];
        if (wr_lane0 && rb.wr_addr == OFS_STATUS)
            stat_nxt = stat_r & ~wbyte[EVT_W-1:0];
        // Set after clear so a same-cycle event is kept
        stat_nxt = stat_nxt | evt;
        // Not gated by any master flag; a new trap re-raises over one in service
        if (TRAP_ACK)
            nmi_nxt = 1'b0;
        if (trap_nmi)
            nmi_nxt = 1'b1;
        // A reset action withdraws any pending trap interrupt at once
        if (trap_rst)
            nmi_nxt = 1'b0;
        // Internal hardware reset returns the configuration to its defaults
        if (rst_busy)
        begin
            ram_sel_nxt  = RST_RAM_SEL;
            ram_live_nxt = RST_RAM_SEL;
            action_nxt   = RST_ACTION;
            mask_nxt     = RST_MASK;
            nmi_nxt      = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ram_sel_r  <= RST_RAM_SEL;
            ram_live_r <= RST_RAM_SEL;
            action_r   <= RST_ACTION;
            nmi_r      <= 1'b0;
            osc_r      <= 1'b0;
            clr_r      <= 1'b0;
            off_r      <= 1'b0;
            mask_r     <= RST_MASK;
            stat_r     <= '0;
        end
        else
        begin
            ram_sel_r  <= ram_sel_nxt;
            ram_live_r <= ram_live_nxt;
            action_r   <= action_nxt;
            nmi_r      <= nmi_nxt;
            osc_r      <= osc_nxt;
            clr_r      <= clr_nxt;
            off_r      <= off_nxt;
            mask_r     <= mask_nxt;
            stat_r     <= stat_nxt;
        end
    end

    // Read side; the code register is write-only and reads zero
    always_comb
    begin
        rb.rd_data = 32'h0000_0000;
        rb.rd_err  = 1'b0;
        case (rb.rd_addr)
            OFS_CTRL_ONE:
            begin
                rb.rd_data[BIT_RAM_SEL] = ram_sel_r;
                rb.rd_data[BIT_ACTION]  = action_r;
            end
            OFS_CODE:   rb.rd_data = 32'h0000_0000;
            OFS_STATUS: rb.rd_data[EVT_W-1:0] = stat_r;
            OFS_MASK:   rb.rd_data[EVT_W-1:0] = mask_r;
            OFS_STATE:  rb.rd_data[2:0] = {rst_busy, nmi_r, ram_live_r};
            default:    rb.rd_err = 1'b1;
        endcase
    end

    always_comb
    begin
        case (rb.wr_addr)
            OFS_CTRL_ONE, OFS_CODE, OFS_STATUS, OFS_MASK, OFS_STATE:
                rb.wr_err = 1'b0;
            default:
                rb.wr_err = 1'b1;
        endcase
    end

    assign TRAP_NMI      = nmi_r;
    assign TRAP_RESET    = rst_busy;
    assign HFOSC_RESTART = osc_r;
    assign WDT_CLEAR     = clr_r;
    assign WDT_DISABLE   = off_r;
    assign IRQ           = |(stat_r & mask_r);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence code_write(logic [7:0] c);
        wr_lane0 && rb.wr_addr == OFS_CODE && wbyte == c;
    endsequence
    sequence sel_staged;
        wr_lane0 && rb.wr_addr == OFS_CTRL_ONE && !rst_busy;
    endsequence

    ram_gate_a: assert property (FETCH_VALID && in_ram && !in_sfr && !ram_live_r
                                 |-> !trap_hit)
        else $error("RAM fetch trapped while RAM trap off");
    sel_apply_a: assert property (sel_staged ##1 !(wr_lane0 && rb.wr_addr == OFS_CODE)
                                  && !rst_busy |=> $stable(ram_live_r))
        else $error("RAM select applied without trap area code");
    code_apply_a: assert property (code_write(CODE_TRAP_AREA) and ##0 !rst_busy
                                   |=> ram_live_r == $past(ram_sel_r))
        else $error("Trap area code did not apply selection");
    sfr_trap_a: assert property (FETCH_VALID && in_sfr && !rst_busy
                                 |-> trap_hit)
        else $error("Special area fetch not trapped");
    nmi_raise_a: assert property (trap_hit && !action_r |=> TRAP_NMI)
        else $error("Trap interrupt not raised");
    nest_trap_a: assert property (TRAP_NMI && trap_nmi && TRAP_ACK
                                  |=> TRAP_NMI)
        else $error("Trap lost against acknowledge");
    rst_act_a: assert property (trap_hit && action_r |=> TRAP_RESET && !TRAP_NMI)
        else $error("Reset action did not start reset");
    osc_kick_a: assert property (trap_rst && SLOW_MODE |=> HFOSC_RESTART ##1 TRAP_RESET)
        else $error("Oscillator not restarted in slow mode");
    wdt_code_a: assert property (code_write(CODE_WDT_CLEAR) |=> WDT_CLEAR && !WDT_DISABLE)
        else $error("Clear code not decoded");
    bad_code_a: assert property (wr_lane0 && rb.wr_addr == OFS_CODE && wbyte != CODE_WDT_CLEAR
                                 && wbyte != CODE_WDT_OFF |=> !WDT_CLEAR && !WDT_DISABLE)
        else $error("Invalid code had an effect");
    ctrl_share_a: assert property (sel_staged |=> ram_sel_r == $past(wbyte[BIT_RAM_SEL])
                                   && action_r == $past(wbyte[BIT_ACTION]))
        else $error("Control write did not land in trap bits");
    reset_vals_a: assert property ($fell(rst_busy) |-> ram_live_r && action_r)
        else $error("Select bits not one after trap reset");
endmodule : fat_trap

/* verif/fat_cpu_model.sv */
// Purpose: CPU fetch and trap acknowledge model
// Assumes: Trap request is taken only while ack_en is high
// Notes:   Idle fetch address is inverted so a stale value never matches
`timescale 1ns/1ps
module fat_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ack_en,
    input  wire logic        trap_nmi,
    output      logic        fetch_valid,
    output      logic [15:0] fetch_addr,
    output      logic        trap_ack
);
    // Fetch starts idle, its address outside both trap windows
    initial
    begin
        fetch_valid = 1'b0;
        fetch_addr  = 16'hffff;
    end

    task automatic fetch(input logic [15:0] a);
        @(posedge clk);
        fetch_valid <= 1'b1;
        fetch_addr  <= a;
        @(posedge clk);
        fetch_valid <= 1'b0;
        fetch_addr  <= ~a;
    endtask : fetch

    // Takes the trap only while ack_en is high, returns with one ack each
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            trap_ack <= 1'b0;
        else
            trap_ack <= ack_en && trap_nmi && !trap_ack;
    end
endmodule : fat_cpu_model

/* verif/testbench.sv */
// Purpose: Self-checking bench for the fetch address trap unit
// Assumes: AXI4-Lite master, CPU model on the fetch side
// Notes:   Outputs are sampled at the falling edge, where they are settled
`timescale 1ns/1ps
module testbench;
    import fat_pkg::*;
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, slow, ack_en;
    logic        awready, wready, bvalid, arready, rvalid, fv, ack, nmi, trst;
    logic        hfo, wclr, wdis, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] fa;
    int          fail_count, checks_done, n_rst, n_hfo, n_clr, n_dis;

    fat_trap u_dut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .FETCH_VALID(fv), .FETCH_ADDR(fa), .SLOW_MODE(slow), .TRAP_ACK(ack),
        .TRAP_NMI(nmi), .TRAP_RESET(trst), .HFOSC_RESTART(hfo), .WDT_CLEAR(wclr),
        .WDT_DISABLE(wdis), .IRQ(irq));
    fat_cpu_model u_cpu (.clk(clk), .rst(rst), .ack_en(ack_en), .trap_nmi(nmi),
        .fetch_valid(fv), .fetch_addr(fa), .trap_ack(ack));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulse and length counters; pulses are too short to poll from tasks
    always @(posedge clk)
    begin
        n_rst <= n_rst + int'(trst);
        n_hfo <= n_hfo + int'(hfo);
        n_clr <= n_clr + int'(wclr);
        n_dis <= n_dis + int'(wdis);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw, w, b;
        logic [1:0] r;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(negedge clk);
            aw = awready;
            w  = wready;
            b  = bvalid;
            r  = bresp;
            @(posedge clk);
            if (aw)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
            if (b)
                break;
        end
        bready <= 1'b0;
        chk(32'(r), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic        ar, v;
        logic [31:0] d;
        logic [1:0]  rr;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(negedge clk);
            ar = arready;
            v  = rvalid;
            d  = rdata;
            rr = rresp;
            @(posedge clk);
            if (ar)
                arvalid <= 1'b0;
            if (v)
                break;
        end
        rready <= 1'b0;
        chk(d, exp);
        chk(32'(rr), 32'(a > OFS_STATE ? RESP_SLVERR : RESP_OKAY));
    endtask : rd

    task automatic trap_case(input logic [15:0] a, input logic exp);
        wr(OFS_STATUS, 32'h3, RESP_OKAY);
        u_cpu.fetch(a);
        cyc(4);
        rd(OFS_STATUS, {31'h0, exp});
    endtask : trap_case

    task automatic t_reset();
        rd(OFS_CTRL_ONE, 32'h30);
        rd(OFS_STATE, 32'h1);
        rd(OFS_CODE, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h14, 32'h0, RESP_SLVERR);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_nmi();
        wr(OFS_CTRL_ONE, 32'h20, RESP_OKAY);
        wr(OFS_MASK, 32'h3, RESP_OKAY);
        @(posedge clk);
        ack_en <= 1'b0;
        u_cpu.fetch(16'h0010);
        cyc(4);
        chk(32'({nmi, irq, trst}), 32'h6);
        rd(OFS_STATE, 32'h3);
        @(posedge clk);
        ack_en <= 1'b1;
        // Second trap lands on the same edge as the first acknowledge
        u_cpu.fetch(16'h0020);
        cyc(0);
        chk(32'(nmi), 32'h1);
        cyc(4);
        chk(32'(nmi), 32'h0);
        wr(OFS_STATUS, 32'h1, RESP_OKAY);
        cyc(1);
        chk(32'(irq), 32'h0);
        $display("test trap interrupt done");
    endtask : t_nmi

    task automatic t_ram();
        trap_case(16'h0100, 1'b1);
        wr(OFS_CTRL_ONE, 32'h0, RESP_OKAY);
        trap_case(RAM_HI, 1'b1);
        wr(OFS_CODE, 32'hd2, RESP_OKAY);
        rd(OFS_STATE, 32'h0);
        trap_case(RAM_LO, 1'b0);
        trap_case(SFR_HI, 1'b1);
        trap_case(16'h0240, 1'b0);
        $display("test ram selection done");
    endtask : t_ram

    task automatic t_rtrap();
        int r0, h0;
        r0 = n_rst;
        h0 = n_hfo;
        wr(OFS_CTRL_ONE, 32'h10, RESP_OKAY);
        @(posedge clk);
        slow <= 1'b1;
        u_cpu.fetch(SFR_LO);
        cyc(32);
        chk(32'(n_rst - r0), 32'd24);
        chk(32'(n_hfo - h0), 32'h1);
        rd(OFS_STATUS, 32'h2);
        rd(OFS_CTRL_ONE, 32'h30);
        rd(OFS_STATE, 32'h1);
        chk(32'(irq), 32'h0);
        @(posedge clk);
        slow <= 1'b0;
        // Normal mode: reset again, oscillator left alone
        u_cpu.fetch(SFR_HI);
        cyc(32);
        chk(32'(n_rst - r0), 32'd48);
        chk(32'(n_hfo - h0), 32'h1);
        $display("test trap reset done");
    endtask : t_rtrap

    task automatic t_codes();
        logic [7:0] codes [4];
        int         c0, d0;
        codes = '{8'h4e, 8'hb1, 8'hd2, 8'h55};
        c0 = n_clr;
        d0 = n_dis;
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CODE, {24'h0, codes[i]}, RESP_OKAY);
            cyc(2);
            chk(32'(n_clr - c0), 32'h1);
            chk(32'(n_dis - d0), 32'(i > 0));
        end
        $display("test code register done");
    endtask : t_codes

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    initial
    begin
        {rst, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h40;
        {awaddr, araddr, wdata} = '0;
        {fail_count, checks_done, n_rst, n_hfo, n_clr, n_dis} = '0;
        wstrb  = 4'hf;
        ack_en = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_nmi();
        t_ram();
        t_rtrap();
        t_codes();
        final_report();
    end

    // All tests take a few hundred cycles; the 20000-cycle limit far above that means a hang
    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end
endmodule : testbench
